// ===== verilog/touch_pkg.sv
// shared constants for the touch decision and reporting block
package touch_pkg;
	localparam int NUM_BTN = 8;
	localparam int NUM_CH = 9;
	localparam int PROX_CH = 8;
	localparam int TICK_W = 10;
	localparam int LVL_W = 12;
	localparam int IDX_W = 3;
	localparam int CNT_W = 3;
	localparam int AOI_W = 4;

	localparam logic [7:0] ADDR_BTN_STATUS = 8'h00;
	localparam logic [7:0] ADDR_PROX_STATUS = 8'h01;
	localparam logic [7:0] ADDR_BUTTON_CONFIG = 8'h22;
	localparam logic [7:0] ADDR_BUTTON_HYST = 8'h26;
	localparam logic [7:0] ADDR_STUCK_TIMEOUT = 8'h27;
	localparam logic [7:0] ADDR_STRONGEST_MARGIN = 8'h28;
	localparam logic [7:0] ADDR_LONG_PRESS = 8'h29;

	localparam logic [7:0] RST_BUTTON_CONFIG = 8'h70;
	localparam logic [7:0] RST_BUTTON_HYST = 8'h0a;
	localparam logic [7:0] RST_STUCK_TIMEOUT = 8'h00;
	localparam logic [7:0] RST_STRONGEST_MARGIN = 8'h80;
	localparam logic [7:0] RST_LONG_PRESS = 8'h00;

	localparam int CFG_MODE_LO = 6;
	localparam int CFG_IRQ_LO = 4;
	localparam int CFG_REL_DB = 3;
	localparam int CFG_TDB_LO = 0;
	localparam int STAT_PROX = 0;
	localparam int STAT_IRQ = 1;
	localparam int IRQ_ON_TOUCH = 0;
	localparam int IRQ_ON_RELEASE = 1;

	localparam logic [1:0] MODE_ALL = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_STRONGEST = 2'h2;

	localparam logic [2:0] TDB_MAX_CODE = 3'h3;
	localparam logic [2:0] REL_DB_SAMPLES = 3'h2;
	localparam logic [7:0] TIMER_OFF = 8'h00;
	localparam logic [3:0] AOI_IDLE = 4'h0;
	localparam logic [3:0] AOI_PROX = 4'h9;
	localparam int PCT_FULL = 100;

	localparam int ONE_SECOND_NS = 1000000000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SEC_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
endpackage

// ===== verilog/second_timer.sv
// whole-second timer, counts shared second ticks while running
`timescale 1ns/10ps
module second_timer
	import touch_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic run,
	input wire logic sec_pulse,
	input wire logic [7:0] limit,
	output logic expired
);
	typedef struct packed {
		logic [7:0] count;
		logic expired;
	} timer_state_t;

	timer_state_t s;
	timer_state_t next_s;

	// the second tick is free running, so the first second may be short
	always_comb begin
		next_s = s;
		if (!run || limit == TIMER_OFF) begin
			next_s = '0;
		end else if (sec_pulse && !s.expired) begin
			next_s.count = s.count + 8'h01;
			if (s.count + 8'h01 == limit) begin
				next_s.expired = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expired = s.expired;

	AST_TIMER_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
		(limit == TIMER_OFF) |=> !expired) else $error("timer expired while disabled");
endmodule

// ===== verilog/touch_channel.sv
// per-sensor threshold, hysteresis, debounce and stuck-touch decision
`timescale 1ns/10ps
module touch_channel
	import touch_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scan_tick,
	input wire logic sec_pulse,
	input wire logic [TICK_W-1:0] ticks,
	input wire logic [TICK_W-1:0] threshold,
	input wire logic [7:0] hyst_pct,
	input wire logic [2:0] touch_db,
	input wire logic release_db,
	input wire logic [7:0] stuck_limit,
	output logic touched,
	output logic comp_req
);
	typedef struct packed {
		logic touched;
		logic blocked;
		logic comp_req;
		logic [CNT_W-1:0] cnt;
	} chan_state_t;

	chan_state_t s;
	chan_state_t next_s;
	logic [LVL_W-1:0] hyst;
	logic [LVL_W-1:0] upper;
	logic [LVL_W-1:0] lower;
	logic above;
	logic below;
	logic stuck_exp;
	logic [CNT_W-1:0] touch_need;
	logic [CNT_W-1:0] cnt_inc;

	always_comb begin
		hyst = LVL_W'((18'(threshold) * 18'(hyst_pct)) / 18'(PCT_FULL));
		upper = LVL_W'(threshold) + hyst;
		lower = (LVL_W'(threshold) > hyst) ? LVL_W'(threshold) - hyst : '0;
	end

	assign above = LVL_W'(ticks) > upper;
	assign below = LVL_W'(ticks) < lower;
	// codes above the last documented one saturate at four samples
	assign touch_need = (touch_db > TDB_MAX_CODE) ? TDB_MAX_CODE + 3'h1 : touch_db + 3'h1; // R16
	assign cnt_inc = s.cnt + 3'h1;

	second_timer u_stuck (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(s.touched),
		.sec_pulse(sec_pulse),
		.limit(stuck_limit),
		.expired(stuck_exp)
	);

	always_comb begin
		next_s = s;
		next_s.comp_req = 1'b0;
		if (s.touched && stuck_exp) begin // R1 R17
			next_s.touched = 1'b0;
			next_s.blocked = 1'b1;
			next_s.comp_req = 1'b1;
			next_s.cnt = '0;
		end else if (scan_tick) begin
			if (!s.touched) begin
				if (s.blocked) begin
					// a held finger must lift before it can count again
					next_s.blocked = !below; // R17
					next_s.cnt = '0;
				end else if (above) begin // R5
					if (cnt_inc >= touch_need) begin // R6
						next_s.touched = 1'b1;
						next_s.cnt = '0;
					end else begin
						next_s.cnt = cnt_inc;
					end
				end else begin
					next_s.cnt = '0;
				end
			end else if (below) begin
				if (!release_db || cnt_inc >= REL_DB_SAMPLES) begin // R7
					next_s.touched = 1'b0;
					next_s.cnt = '0;
				end else begin
					next_s.cnt = cnt_inc;
				end
			end else begin
				next_s.cnt = '0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign touched = s.touched;
	assign comp_req = s.comp_req;

	AST_RELEASE_FAST: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
		(scan_tick && s.touched && below && !release_db) |=> !touched)
		else $error("release not taken on first low sample");
	AST_DEBOUNCE_TWO: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
		($rose(touched) && $past(touch_db) == 3'h1) |-> $past(s.cnt) == 3'h1 && $past(above))
		else $error("touch validated before two qualifying samples");
	AST_STUCK_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
		(s.touched && stuck_exp) |=> !touched && comp_req ##1 !comp_req)
		else $error("stuck touch not released with one compensation pulse");
endmodule

// ===== verilog/touch_report.sv
// button and proximity decision, selection and reporting
// Contract
// R1: stuck timeout 0 is off, 1..255 gives seconds, buttons and proximity alike.
// R2: strongest margin used only in Strongest mode; proximity never selected as strongest.
// R3: another button wins only when it beats the current one by the margin (default 128).
// R4: long-press limit cuts analog output in Single mode only; proximity never starts it.
// R5: touch debounce counts once ticks exceed threshold plus hysteresis.
// R6: touch debounce field one needs two consecutive qualifying samples.
// R7: release debounce bit clear releases on first sample below threshold minus hysteresis.
// R8: All mode reports every touched button together with proximity.
// R9: Single mode reports one touch and proximity, ignores others until it releases.
// R10: Strongest mode moves the report to a sensor rising above the reported one.
// R11: Single/Strongest analog output implies proximity under a button, never separately.
// R12: interrupt on touch, release or both as configured.
// R13: All mode analog idle; buzzer follows buttons; LEDs follow buttons and proximity.
// R14: mode field 00 All, 01 Single (default), 10 Strongest, 11 reserved.
// R15: interrupt field 00 masked, 01 touch, 10 release, 11 both (default).
// R16: touch debounce 00 none, 01..11 gives 2, 3 or 4 samples per scan.
// R17: stuck timeout expiry compensates, releases the button, later touches report normally.
`timescale 1ns/10ps
module touch_report
	import touch_pkg::*;
#(
	parameter int SECOND_CYCLES = SEC_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scan_tick,
	input wire logic [NUM_CH-1:0][TICK_W-1:0] ticks,
	input wire logic [NUM_CH-1:0][TICK_W-1:0] thresholds,
	input wire logic [7:0] prox_hyst_pct,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq_out_n,
	output logic [NUM_CH-1:0] led_out,
	output logic buzzer_out,
	output logic [AOI_W-1:0] aoi_level,
	output logic comp_req
);
	typedef struct packed {
		logic [7:0] button_config;
		logic [7:0] button_hyst;
		logic [7:0] stuck_timeout;
		logic [7:0] strongest_margin;
		logic [7:0] long_press_limit;
		logic sel_valid;
		logic [IDX_W-1:0] sel_idx;
		logic [NUM_BTN-1:0] rep_btn;
		logic rep_prox;
		logic irq_pend;
		logic irq_n;
		logic [NUM_CH-1:0] led;
		logic buzzer;
		logic [AOI_W-1:0] aoi;
		logic comp;
		logic [7:0] rdata;
		logic [31:0] sec_cnt;
		logic sec_pulse;
	} top_state_t;

	top_state_t s;
	top_state_t next_s;
	logic [NUM_CH-1:0] touched;
	logic [NUM_CH-1:0] chan_comp;
	logic [1:0] mode;
	logic [1:0] irq_sel;
	logic lp_run;
	logic lp_exp;
	logic best_valid;
	logic [IDX_W-1:0] best_idx;
	logic [IDX_W-1:0] low_idx;
	logic any_btn;
	logic sel_held;
	logic over_margin;
	logic status_read;

	assign mode = s.button_config[CFG_MODE_LO +: 2]; // R14
	assign irq_sel = s.button_config[CFG_IRQ_LO +: 2]; // R15
	assign any_btn = |touched[NUM_BTN-1:0];
	assign sel_held = s.sel_valid && touched[s.sel_idx];
	assign status_read = reg_rd && reg_addr == ADDR_BTN_STATUS;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		touch_channel u_ch (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.scan_tick(scan_tick),
			.sec_pulse(s.sec_pulse),
			.ticks(ticks[c]),
			.threshold(thresholds[c]),
			.hyst_pct((c == PROX_CH) ? prox_hyst_pct : s.button_hyst),
			.touch_db(s.button_config[CFG_TDB_LO +: 3]),
			.release_db(s.button_config[CFG_REL_DB]),
			.stuck_limit(s.stuck_timeout),
			.touched(touched[c]),
			.comp_req(chan_comp[c])
		);
	end

	// proximity never starts the timer: it runs only on a held button report
	assign lp_run = (mode == MODE_SINGLE) && sel_held; // R4

	second_timer u_long_press (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(lp_run),
		.sec_pulse(s.sec_pulse),
		.limit(s.long_press_limit),
		.expired(lp_exp)
	);

	// scan buttons only; proximity is left out of both searches
	always_comb begin
		best_valid = 1'b0;
		best_idx = '0;
		low_idx = '0;
		for (int i = 0; i < NUM_BTN; i++) begin // R2
			if (touched[i] && (!best_valid || ticks[i] > ticks[best_idx])) begin
				best_valid = 1'b1;
				best_idx = IDX_W'(i);
			end
		end
		for (int i = NUM_BTN - 1; i >= 0; i--) begin
			if (touched[i]) begin
				low_idx = IDX_W'(i);
			end
		end
	end

	// margin kept wide so 1023 ticks plus 255 cannot wrap
	assign over_margin = best_valid && best_idx != s.sel_idx &&
		LVL_W'(ticks[best_idx]) >= LVL_W'(ticks[s.sel_idx]) + LVL_W'(s.strongest_margin); // R3

	always_comb begin
		logic touch_ev;
		logic rel_ev;
		touch_ev = 1'b0;
		rel_ev = 1'b0;
		next_s = s;

		next_s.sec_pulse = 1'b0;
		if (s.sec_cnt >= 32'(SECOND_CYCLES - 1)) begin
			next_s.sec_cnt = '0;
			next_s.sec_pulse = 1'b1;
		end else begin
			next_s.sec_cnt = s.sec_cnt + 32'h1;
		end

		if (reg_wr) begin
			case (reg_addr)
				ADDR_BUTTON_CONFIG: next_s.button_config = reg_wdata;
				ADDR_BUTTON_HYST: next_s.button_hyst = reg_wdata;
				ADDR_STUCK_TIMEOUT: next_s.stuck_timeout = reg_wdata;
				ADDR_STRONGEST_MARGIN: next_s.strongest_margin = reg_wdata;
				ADDR_LONG_PRESS: next_s.long_press_limit = reg_wdata;
				default: ;
			endcase
		end

		case (mode)
			MODE_SINGLE: begin
				if (!sel_held) begin // R9
					next_s.sel_valid = any_btn;
					next_s.sel_idx = low_idx;
				end
			end
			MODE_STRONGEST: begin
				if (!sel_held) begin // R10
					next_s.sel_valid = best_valid;
					next_s.sel_idx = best_idx;
				end else if (over_margin) begin // R2 R3 R10
					next_s.sel_idx = best_idx;
				end
			end
			default: begin
				// reserved code behaves as All
				next_s.sel_valid = 1'b0;
				next_s.sel_idx = '0;
			end
		endcase

		if (mode == MODE_SINGLE || mode == MODE_STRONGEST) begin
			next_s.rep_btn = next_s.sel_valid ? NUM_BTN'(1) << next_s.sel_idx : '0; // R9 R10
		end else begin
			next_s.rep_btn = touched[NUM_BTN-1:0]; // R8
		end
		next_s.rep_prox = touched[PROX_CH]; // R8 R9

		touch_ev = |(next_s.rep_btn & ~s.rep_btn) || (next_s.rep_prox && !s.rep_prox);
		rel_ev = |(~next_s.rep_btn & s.rep_btn) || (!next_s.rep_prox && s.rep_prox);
		// a new event in the cycle of the status read keeps the interrupt pending
		next_s.irq_pend = (s.irq_pend && !status_read) ||
			(touch_ev && irq_sel[IRQ_ON_TOUCH]) ||
			(rel_ev && irq_sel[IRQ_ON_RELEASE]); // R12 R15
		next_s.irq_n = !next_s.irq_pend;

		next_s.led = touched; // R13
		next_s.buzzer = |next_s.rep_btn; // R13
		next_s.comp = |chan_comp; // R17

		if (mode == MODE_SINGLE || mode == MODE_STRONGEST) begin
			if (s.sel_valid) begin
				// an expired long press goes idle, not to proximity
				next_s.aoi = (lp_exp && mode == MODE_SINGLE) ? AOI_IDLE : // R4
					AOI_W'(s.sel_idx) + 4'h1; // R11
			end else if (touched[PROX_CH]) begin
				next_s.aoi = AOI_PROX; // R11
			end else begin
				next_s.aoi = AOI_IDLE;
			end
		end else begin
			next_s.aoi = AOI_IDLE; // R13
		end

		if (reg_rd) begin
			case (reg_addr)
				ADDR_BTN_STATUS: next_s.rdata = s.rep_btn;
				ADDR_PROX_STATUS: begin
					next_s.rdata = '0;
					next_s.rdata[STAT_PROX] = s.rep_prox;
					next_s.rdata[STAT_IRQ] = s.irq_pend;
				end
				ADDR_BUTTON_CONFIG: next_s.rdata = s.button_config;
				ADDR_BUTTON_HYST: next_s.rdata = s.button_hyst;
				ADDR_STUCK_TIMEOUT: next_s.rdata = s.stuck_timeout;
				ADDR_STRONGEST_MARGIN: next_s.rdata = s.strongest_margin;
				ADDR_LONG_PRESS: next_s.rdata = s.long_press_limit;
				default: next_s.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
			s.button_config <= RST_BUTTON_CONFIG;
			s.button_hyst <= RST_BUTTON_HYST;
			s.stuck_timeout <= RST_STUCK_TIMEOUT;
			s.strongest_margin <= RST_STRONGEST_MARGIN;
			s.long_press_limit <= RST_LONG_PRESS;
			s.irq_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign irq_out_n = s.irq_n;
	assign led_out = s.led;
	assign buzzer_out = s.buzzer;
	assign aoi_level = s.aoi;
	assign comp_req = s.comp;

	AST_TOUCH_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
		($past(irq_sel[IRQ_ON_TOUCH]) && |(s.rep_btn & ~$past(s.rep_btn))) |-> !irq_out_n)
		else $error("touch report raised no interrupt");
	AST_IRQ_MASKED: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
		(irq_sel == 2'h0 && irq_out_n) |=> irq_out_n)
		else $error("masked interrupt fired");
	AST_ALL_AOI_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
		(mode == MODE_ALL) |=> aoi_level == AOI_IDLE)
		else $error("analog output not idle in All mode");
	AST_ALL_REPORT: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
		(mode == MODE_ALL) |=> s.rep_btn == $past(touched[NUM_BTN-1:0]))
		else $error("All mode lost a simultaneous touch");
	AST_ONE_REPORTED: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
		(mode == MODE_SINGLE || mode == MODE_STRONGEST) |=> $onehot0(s.rep_btn))
		else $error("more than one button reported");
	AST_SINGLE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
		(mode == MODE_SINGLE && sel_held && !reg_wr) |=> $stable(s.sel_idx) && s.sel_valid)
		else $error("single report moved while first touch held");
	AST_MARGIN_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
		(mode == MODE_STRONGEST && sel_held && !over_margin && !reg_wr) |=> $stable(s.sel_idx))
		else $error("strongest switched without margin");
	AST_PROX_IMPLIED: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
		(mode != MODE_ALL && s.sel_valid) |=> aoi_level != AOI_PROX)
		else $error("proximity shown on analog output under a button");
	AST_LONG_PRESS_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
		(mode == MODE_SINGLE && s.sel_valid && lp_exp) |=> aoi_level == AOI_IDLE)
		else $error("analog output held after long press limit");
	AST_BUZZ_BUTTONS: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
		buzzer_out == (s.rep_btn != '0))
		else $error("buzzer does not follow button reports");
	AST_RELEASE_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
		($past(irq_sel[IRQ_ON_RELEASE]) && |(~s.rep_btn & $past(s.rep_btn))) |-> !irq_out_n)
		else $error("release report raised no interrupt");
	AST_READ_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
		(status_read && next_s.rep_btn == s.rep_btn && next_s.rep_prox == s.rep_prox) |=> irq_out_n)
		else $error("status read left the interrupt pending");
	AST_PROX_AOI: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
		(mode == MODE_SINGLE && !s.sel_valid && touched[PROX_CH]) |=> aoi_level == AOI_PROX)
		else $error("proximity alone not shown on analog output");
	AST_LONG_PRESS_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
		(s.long_press_limit == TIMER_OFF) |=> !lp_exp)
		else $error("long press expired while disabled");
	AST_RESERVED_ALL: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
		(mode == 2'h3) |=> s.rep_btn == $past(touched[NUM_BTN-1:0]) && aoi_level == AOI_IDLE)
		else $error("reserved mode does not behave as All");
endmodule

// ===== bench/touch_host.sv
// host model driving the register port of the reporting block
`timescale 1ns/10ps
module touch_host
	import touch_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		// released data lines show a changed value, not the last one
		reg_wdata = ~d;
	endtask
	// data is taken a full cycle after the strobe; it holds until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		@(posedge clk_sys);
		#1;
		d = reg_rdata;
	endtask
endmodule

// ===== bench/test_touch_report.sv
// self-checking bench for the touch decision and reporting block
`timescale 1ns/10ps
module test_touch_report
	import touch_pkg::*;
;
	localparam int SEC = 20;
	logic clk_sys;
	logic rst_n;
	logic scan_tick;
	logic [NUM_CH-1:0][TICK_W-1:0] tk;
	logic [NUM_CH-1:0][TICK_W-1:0] thr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic irq_out_n;
	logic [NUM_CH-1:0] led_out;
	logic buzzer_out;
	logic [AOI_W-1:0] aoi_level;
	logic comp_req;
	logic [7:0] rv;
	logic [7:0] ra [5];
	logic [7:0] rr [5];
	int n_fail;
	int cmp_count;
	int seed;
	int lvl [NUM_CH];
	int up;
	int lo;
	int seen;

	touch_report #(.SECOND_CYCLES(SEC)) u_dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.scan_tick(scan_tick),
		.ticks(tk),
		.thresholds(thr),
		.prox_hyst_pct(RST_BUTTON_HYST),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.irq_out_n(irq_out_n),
		.led_out(led_out),
		.buzzer_out(buzzer_out),
		.aoi_level(aoi_level),
		.comp_req(comp_req)
	);
	touch_host u_host (
		.clk_sys(clk_sys),
		.reg_rdata(reg_rdata),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	function automatic int trip(input int t, input int p, input int s);
		return t + s * (t * p / PCT_FULL);
	endfunction
	function automatic int idle();
		return $unsigned($random(seed)) % lo;
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// idle channels get fresh random ticks below the lower trip on every scan
	task automatic scan(input int n);
		repeat (n) begin
			@(negedge clk_sys);
			for (int i = 0; i < NUM_CH; i++) begin
				tk[i] = TICK_W'(lvl[i] > 0 ? lvl[i] : idle());
			end
			scan_tick = 1'b1;
			@(negedge clk_sys);
			scan_tick = 1'b0;
			repeat (3) @(negedge clk_sys);
		end
	endtask
	task automatic cf(input logic [1:0] m, input logic [1:0] f, input logic r, input logic [2:0] d);
		u_host.wr(ADDR_BUTTON_CONFIG, {m, f, r, d});
	endtask
	task automatic clear();
		for (int i = 0; i < NUM_CH; i++) begin
			lvl[i] = 0;
		end
		scan(2);
		u_host.rd(ADDR_BTN_STATUS, rv);
	endtask
	task automatic pulses(input int n);
		seen = 0;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			if (comp_req === 1'b1) begin
				seen++;
			end
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end

	initial begin
		seed = 32'h571013ba;
		n_fail = 0;
		cmp_count = 0;
		up = 100 + $unsigned($random(seed)) % 300;
		lo = trip(up, int'(RST_BUTTON_HYST), -1);
		up = trip(up, int'(RST_BUTTON_HYST), 1);
		for (int i = 0; i < NUM_CH; i++) begin
			thr[i] = TICK_W'(trip(up, 0, 0));
			tk[i] = '0;
			lvl[i] = 0;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			thr[i] = TICK_W'((lo + up) / 2);
		end
		rst_n = 1'b0;
		scan_tick = 1'b0;
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		ra = '{ADDR_BUTTON_CONFIG, ADDR_BUTTON_HYST, ADDR_STUCK_TIMEOUT,
			ADDR_STRONGEST_MARGIN, ADDR_LONG_PRESS};
		rr = '{RST_BUTTON_CONFIG, RST_BUTTON_HYST, RST_STUCK_TIMEOUT,
			RST_STRONGEST_MARGIN, RST_LONG_PRESS};
		for (int i = 0; i < 5; i++) begin
			u_host.rd(ra[i], rv);
			chk("reset", 16'(rv), 16'(rr[i]));
		end
		for (int i = 2; i < 5; i++) begin
			u_host.wr(ra[i], 8'($random(seed)));
			u_host.wr(ra[i], reg_wdata);
			u_host.rd(ra[i], rv);
			chk("readback", 16'(rv), {8'h00, ~reg_wdata});
			u_host.wr(ra[i], rr[i]);
		end
		u_host.rd(8'h5a, rv);
		chk("unmapped", 16'(rv), 16'h0000);
		u_host.wr(ADDR_PROX_STATUS, 8'hff);
		u_host.rd(ADDR_PROX_STATUS, rv);
		chk("status read only", 16'(rv), 16'h0000);
		// trip points are taken from the threshold actually driven
		up = trip(int'(thr[0]), int'(RST_BUTTON_HYST), 1);
		lo = trip(int'(thr[0]), int'(RST_BUTTON_HYST), -1);
		// the last pass uses code 7, which must act as four samples
		for (int d = 0; d < 5; d++) begin
			cf(MODE_SINGLE, 2'b11, d[0], (d > 3) ? 3'h7 : 3'(d));
			lvl[2] = up;
			scan(2);
			chk("at upper trip", 16'(led_out[2]), 16'h0);
			lvl[2] = up + 1;
			scan((d > 3) ? 3 : d);
			chk("debouncing", 16'(led_out[2]), 16'h0);
			scan(1);
			chk("touched", 16'(led_out[2]), 16'h1);
			lvl[2] = lo;
			scan(1);
			chk("at lower trip", 16'(led_out[2]), 16'h1);
			lvl[2] = lo - 1;
			scan(1);
			chk("release", 16'(led_out[2]), 16'(d[0]));
			clear();
		end
		for (int f = 0; f < 4; f++) begin
			cf(MODE_SINGLE, 2'(f), 1'b0, 3'h0);
			lvl[2] = up + 1;
			scan(1);
			chk("irq touch", 16'(irq_out_n), 16'(!f[0]));
			chk("aoi single", 16'(aoi_level), 16'h3);
			lvl[5] = up + 50;
			scan(1);
			u_host.rd(ADDR_BTN_STATUS, rv);
			chk("single status", 16'(rv), 16'h0004);
			chk("buzzer", 16'(buzzer_out), 16'h1);
			chk("irq cleared", 16'(irq_out_n), 16'h1);
			lvl[2] = 0;
			lvl[5] = 0;
			scan(1);
			chk("irq release", 16'(irq_out_n), 16'(!f[1]));
			clear();
		end
		lvl[8] = up + 1;
		scan(1);
		chk("aoi prox", 16'(aoi_level), 16'(AOI_PROX));
		lvl[3] = up + 1;
		scan(1);
		chk("aoi button", 16'(aoi_level), 16'h4);
		clear();
		cf(MODE_ALL, 2'b11, 1'b0, 3'h0);
		lvl[0] = up + 1;
		lvl[7] = up + 9;
		lvl[8] = up + 1;
		scan(1);
		chk("all leds", 16'(led_out), 16'h0181);
		chk("aoi all", 16'(aoi_level), 16'(AOI_IDLE));
		u_host.rd(ADDR_BTN_STATUS, rv);
		chk("all status", 16'(rv), 16'h0081);
		u_host.rd(ADDR_PROX_STATUS, rv);
		chk("prox status", 16'(rv[STAT_PROX]), 16'h1);
		lvl[0] = 0;
		lvl[7] = 0;
		scan(1);
		chk("buzzer prox", 16'(buzzer_out), 16'h0);
		clear();
		cf(2'b11, 2'b11, 1'b0, 3'h0);
		lvl[1] = up + 1;
		lvl[6] = up + 1;
		scan(1);
		u_host.rd(ADDR_BTN_STATUS, rv);
		chk("reserved status", 16'(rv), 16'h0042);
		chk("reserved aoi", 16'(aoi_level), 16'(AOI_IDLE));
		clear();
		cf(MODE_STRONGEST, 2'b11, 1'b0, 3'h0);
		lvl[1] = up + 1;
		scan(1);
		lvl[4] = up + 128;
		scan(1);
		chk("below margin", 16'(aoi_level), 16'h2);
		lvl[8] = 1023;
		scan(1);
		chk("prox excluded", 16'(aoi_level), 16'h2);
		lvl[4] = up + 129;
		scan(1);
		chk("margin reached", 16'(aoi_level), 16'h5);
		clear();
		cf(MODE_SINGLE, 2'b11, 1'b0, 3'h0);
		lvl[3] = up + 1;
		scan(1);
		pulses(3 * SEC);
		chk("stuck off", 16'(seen), 16'h0);
		u_host.wr(ADDR_STUCK_TIMEOUT, 8'h01);
		pulses(3 * SEC);
		chk("stuck pulse", 16'(seen), 16'h1);
		scan(2);
		chk("stuck released", 16'(led_out[3]), 16'h0);
		u_host.wr(ADDR_STUCK_TIMEOUT, RST_STUCK_TIMEOUT);
		lvl[3] = 0;
		scan(1);
		lvl[3] = up + 1;
		scan(1);
		chk("retouch", 16'(led_out[3]), 16'h1);
		clear();
		u_host.wr(ADDR_LONG_PRESS, 8'h02);
		lvl[6] = up + 1;
		scan(1);
		chk("long start", 16'(aoi_level), 16'h7);
		repeat (50) @(negedge clk_sys);
		chk("long idle", 16'(aoi_level), 16'(AOI_IDLE));
		chk("long led", 16'(led_out[6]), 16'h1);
		clear();
		lvl[8] = up + 1;
		scan(1);
		repeat (50) @(negedge clk_sys);
		chk("long prox", 16'(aoi_level), 16'(AOI_PROX));
		clear();
		conclude();
	end
endmodule
